// file: common/cc_regs_pkg.sv
// Purpose: Constants for the charge counter control and status registers
// Assumes: 7-bit register addresses, 8-bit data
// Notes: Threshold voltages are kept in microvolts
package cc_regs_pkg;
    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_CALIBRATED_OFFSET = 7'h73;
    localparam logic [6:0] ADDR_TEMPERATURE_AND_CLEAR = 7'h74;
    localparam logic [6:0] ADDR_MODE_AND_WAKE_THRESHOLD = 7'h75;
    // ----------------------------------------------------------------
    // Mode and wake threshold fields
    // ----------------------------------------------------------------
    localparam int MODE_OVERRIDE_BIT = 7;
    localparam int MODE_CAL_BIT = 6;
    localparam int MODE_CHG_ROLL_BIT = 5;
    localparam int MODE_DSG_ROLL_BIT = 4;
    localparam int MODE_WAKE_MSB = 3;
    localparam int MODE_WAKE_LSB = 1;
    localparam logic [2:0] WAKE_SELECT_RESET = 3'h7;
    localparam logic CAL_REQUEST_RESET = 1'b1;
    // ----------------------------------------------------------------
    // Temperature and clear fields, offset reset value
    // ----------------------------------------------------------------
    localparam int TEMP_MSB = 7;
    localparam int TEMP_LSB = 5;
    localparam int CLR_CHG_TIME_BIT = 4;
    localparam int CLR_DSG_TIME_BIT = 3;
    localparam int CLR_SELF_DSG_BIT = 2;
    localparam int CLR_CHG_COUNT_BIT = 1;
    localparam int CLR_DSG_COUNT_BIT = 0;
    localparam logic [7:0] OFFSET_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Calibration threshold: 3.84 mV divided by the selection
    // ----------------------------------------------------------------
    localparam int THRESHOLD_BASE_UV = 3840;
endpackage

// file: dv/cc_host_model.sv
// Purpose: Host controller model on the register port
// Assumes: Write taken at the edge after the request is set up
// Notes: Released write data is inverted so stale values never match
module cc_host_model
(
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == cc_regs_pkg::ADDR_MODE_AND_WAKE_THRESHOLD)
        begin
            v[0] = 1'b0;
            if (v[3:1] == 3'h0) v[3:1] = 3'h7;
        end
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule

// file: dv/coulomb_counter_control_regs_tb.sv
// Purpose: Self-checking bench for the charge counter registers
// Assumes: Host model owns the register port
// Notes: Outputs sampled on the falling edge, inputs driven on the rising
module coulomb_counter_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] A_OFF = cc_regs_pkg::ADDR_CALIBRATED_OFFSET;
    localparam logic [6:0] A_CLR = cc_regs_pkg::ADDR_TEMPERATURE_AND_CLEAR;
    localparam logic [6:0] A_MODE = cc_regs_pkg::ADDR_MODE_AND_WAKE_THRESHOLD;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic host_line = 1'b1;
    logic [15:0] volt_uv = 16'hFFFF;
    logic [2:0] temp = 3'h5;
    logic ct_wrap = 1'b0;
    logic dt_wrap = 1'b0;
    logic cal_done = 1'b0;
    logic [7:0] cal_offset = 8'h00;
    logic cal_start;
    logic [15:0] thr_uv;
    wire logic [4:0] clr;
    logic [7:0] rv;
    int n_mismatch = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    cc_host_model cc_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    coulomb_counter_control_regs coulomb_counter_control_regs_inst (.clk(clk), .nrst(nrst),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .single_wire_host_line(host_line), .sense_voltage_abs_uv(volt_uv), .temperature_step(temp),
        .charge_time_wrap(ct_wrap), .discharge_time_wrap(dt_wrap), .cal_done(cal_done),
        .cal_offset(cal_offset), .cal_start(cal_start), .calibration_threshold_voltage(thr_uv),
        .clear_charge_time(clr[4]), .clear_discharge_time(clr[3]), .clear_self_discharge(clr[2]),
        .clear_charge_count(clr[1]), .clear_discharge_count(clr[0]));
    // ----------------------------------------------------------------
    // Compare and helper tasks
    // ----------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t threshold %0d expected %0d", $time, got, exp);
        end
    endtask
    // Expected thresholds in microvolts, nearest value
    function automatic logic [15:0] thr_exp(input int s);
        case (s)
            1: thr_exp = 16'h0F00;
            2: thr_exp = 16'h0780;
            3: thr_exp = 16'h0500;
            4: thr_exp = 16'h03C0;
            5: thr_exp = 16'h0300;
            6: thr_exp = 16'h0280;
            7: thr_exp = 16'h0225;
            default: thr_exp = 16'h0000;
        endcase
    endfunction
    task automatic wait_start(output logic seen);
        seen = 1'b0;
        repeat (10)
        begin
            @(negedge clk);
            if (cal_start === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic pulse_done(input logic [7:0] off);
        @(posedge clk);
        cal_done <= 1'b1;
        cal_offset <= off;
        @(posedge clk);
        cal_done <= 1'b0;
        cal_offset <= ~off;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        cc_host_model_inst.rd(A_MODE, rv);
        chk8(rv, 8'h4E);
        chk16(thr_uv, 16'h0225);
        cc_host_model_inst.rd(7'h70, rv);
        chk8(rv, 8'h00);
        cc_host_model_inst.wr(A_OFF, 8'h5A);
        cc_host_model_inst.rd(A_OFF, rv);
        chk8(rv, 8'h5A);
    endtask
    task automatic t_threshold;
        for (int s = 1; s <= 7; s++)
        begin
            cc_host_model_inst.wr(A_MODE, {4'h4, s[2:0], 1'b0});
            cc_host_model_inst.rd(A_MODE, rv);
            chk8(rv, {4'h4, s[2:0], 1'b0});
            chk16(thr_uv, thr_exp(s));
        end
    endtask
    task automatic t_clear;
        for (int i = 0; i < 5; i++)
        begin
            cc_host_model_inst.wr(A_CLR, 8'hE0 | (8'h01 << i));
            @(negedge clk);
            chk8({3'h0, clr}, 8'h01 << i);
            cc_host_model_inst.rd(A_CLR, rv);
            chk8(rv, 8'hA0);
        end
    endtask
    task automatic t_rollover;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            ct_wrap <= (k == 0);
            dt_wrap <= (k == 1);
            @(posedge clk);
            ct_wrap <= 1'b0;
            dt_wrap <= 1'b0;
            cc_host_model_inst.wr(A_MODE, 8'h4E);
            cc_host_model_inst.rd(A_MODE, rv);
            chk8(rv, (k == 0) ? 8'h6E : 8'h5E);
            cc_host_model_inst.wr(A_CLR, (k == 0) ? 8'h10 : 8'h08);
            cc_host_model_inst.rd(A_MODE, rv);
            chk8(rv, 8'h4E);
        end
    endtask
    task automatic t_calibrate;
        logic seen;
        @(posedge clk);
        host_line <= 1'b0;
        volt_uv <= 16'h0258;
        wait_start(seen);
        chk8({7'h0, seen}, 8'h00);
        @(posedge clk);
        volt_uv <= 16'h0064;
        wait_start(seen);
        chk8({7'h0, seen}, 8'h01);
        pulse_done(8'h85);
        cc_host_model_inst.rd(A_MODE, rv);
        chk8(rv, 8'h0E);
        cc_host_model_inst.rd(A_OFF, rv);
        chk8(rv, 8'h85);
        @(posedge clk);
        host_line <= 1'b1;
        volt_uv <= 16'hFFFF;
        cc_host_model_inst.wr(A_MODE, 8'hCE);
        volt_uv <= 16'h0064;
        wait_start(seen);
        chk8({7'h0, seen}, 8'h01);
        pulse_done(8'h3C);
        cc_host_model_inst.rd(A_MODE, rv);
        chk8(rv, 8'h0E);
        cc_host_model_inst.rd(A_OFF, rv);
        chk8(rv, 8'h3C);
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_threshold;
        t_clear;
        t_rollover;
        t_calibrate;
        test_done;
    end
    // Whole run needs under two hundred cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        test_done;
    end
endmodule

// file: rtl/coulomb_counter_control_regs.sv
// Purpose: Control and status registers of a battery charge counter
// Assumes: Register port decoded by the single-wire protocol block
// Notes: Counters live outside; this block issues clear strobes
//
// Overview of operation
// - Calibration request reads 1 until calibration valid
// - Rollover flags bits 5 and 4 on FFFF
// - Calibrate when requested, line low, voltage small
// - Wake threshold selection resets to seven
// - Threshold is 3.84 mV over the selection
// - Temperature step shown in bits 7 to 5
// - Clear bit zeroes both bytes of counter
// - Clear bits return to zero by themselves
// - Each clear bit acts alone
// - Bit 4 clears charge time and flag
// - Bit 3 clears discharge time and flag
// - Bits 2..0 clear self, charge, discharge counters
// - Offset stored as 8-bit two's complement
// - Offset bit 7 gives direction
// - Request cleared in the same cycle as offset update, or by a host write
// - Override skips line low, cleared after calibration
// - Mode register at 75 hex, read-write
module coulomb_counter_control_regs
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Analog and pin side
    input wire logic single_wire_host_line,
    input wire logic [15:0] sense_voltage_abs_uv,
    input wire logic [2:0] temperature_step,
    // Counter events
    input wire logic charge_time_wrap,
    input wire logic discharge_time_wrap,
    // Calibration engine
    input wire logic cal_done,
    input wire logic [7:0] cal_offset,
    output logic cal_start,
    output logic [15:0] calibration_threshold_voltage,
    // Clear strobes to counters
    output logic clear_charge_time,
    output logic clear_discharge_time,
    output logic clear_self_discharge,
    output logic clear_charge_count,
    output logic clear_discharge_count
);
    logic line_s1_reg, line_s2_reg;
    logic override_reg, cal_req_reg, chg_roll_reg, dsg_roll_reg;
    logic [2:0] wake_sel_reg;
    logic [2:0] temp_s1_reg, temp_s2_reg;
    logic [4:0] clear_reg;
    logic [7:0] offset_value;
    logic cal_busy_reg;
    logic wr_mode, wr_tc, wr_ofs, below;

    assign wr_mode = reg_wr && reg_addr == cc_regs_pkg::ADDR_MODE_AND_WAKE_THRESHOLD;
    assign wr_tc = reg_wr && reg_addr == cc_regs_pkg::ADDR_TEMPERATURE_AND_CLEAR;
    assign wr_ofs = reg_wr && reg_addr == cc_regs_pkg::ADDR_CALIBRATED_OFFSET;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            line_s1_reg <= 1'b1;
            line_s2_reg <= 1'b1;
            temp_s1_reg <= 3'h0;
            temp_s2_reg <= 3'h0;
        end
        else
        begin
            line_s1_reg <= single_wire_host_line;
            line_s2_reg <= line_s1_reg;
            temp_s1_reg <= temperature_step;
            temp_s2_reg <= temp_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // Calibration threshold and start
    // ----------------------------------------------------------------
    // Zero selection has no threshold; treat as never below
    // Rounded to nearest so selection 7 gives 549 uV, not 548
    always_comb
    begin
        if (wake_sel_reg == 3'h0)
            calibration_threshold_voltage = 16'h0000;
        else
            calibration_threshold_voltage = 16'((cc_regs_pkg::THRESHOLD_BASE_UV + int'(wake_sel_reg) / 2)
                / int'(wake_sel_reg));
    end
    assign below = sense_voltage_abs_uv < calibration_threshold_voltage;
    // Pulse only once per request until the engine reports back
    assign cal_start = cal_req_reg && !cal_busy_reg && below
        && (override_reg || !line_s2_reg);

    always_ff @(posedge clk)
    begin
        if (!nrst)
            cal_busy_reg <= 1'b0;
        else if (cal_done)
            cal_busy_reg <= 1'b0;
        else if (cal_start)
            cal_busy_reg <= 1'b1;
    end

    // ----------------------------------------------------------------
    // Mode and wake threshold register
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            override_reg <= 1'b0;
            cal_req_reg <= cc_regs_pkg::CAL_REQUEST_RESET;
            wake_sel_reg <= cc_regs_pkg::WAKE_SELECT_RESET;
        end
        else
        begin
            if (wr_mode)
            begin
                override_reg <= reg_wdata[cc_regs_pkg::MODE_OVERRIDE_BIT];
                cal_req_reg <= reg_wdata[cc_regs_pkg::MODE_CAL_BIT];
                wake_sel_reg <= reg_wdata[cc_regs_pkg::MODE_WAKE_MSB:cc_regs_pkg::MODE_WAKE_LSB];
            end
            // Completion wins over a same-cycle host write
            if (cal_done && cal_busy_reg)
            begin
                cal_req_reg <= 1'b0;
                override_reg <= 1'b0;
            end
        end
    end

    // Set wins over clear; mode register writes cannot touch the flags
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            chg_roll_reg <= 1'b0;
            dsg_roll_reg <= 1'b0;
        end
        else
        begin
            if (charge_time_wrap)
                chg_roll_reg <= 1'b1;
            else if (clear_reg[cc_regs_pkg::CLR_CHG_TIME_BIT])
                chg_roll_reg <= 1'b0;
            if (discharge_time_wrap)
                dsg_roll_reg <= 1'b1;
            else if (clear_reg[cc_regs_pkg::CLR_DSG_TIME_BIT])
                dsg_roll_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Clear bits: one-cycle strobes, self-returning to zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            clear_reg <= 5'h00;
        else if (wr_tc)
            clear_reg <= reg_wdata[4:0];
        else
            clear_reg <= 5'h00;
    end
    // Counters must give clear priority over increment
    assign clear_charge_time = clear_reg[cc_regs_pkg::CLR_CHG_TIME_BIT];
    assign clear_discharge_time = clear_reg[cc_regs_pkg::CLR_DSG_TIME_BIT];
    assign clear_self_discharge = clear_reg[cc_regs_pkg::CLR_SELF_DSG_BIT];
    assign clear_charge_count = clear_reg[cc_regs_pkg::CLR_CHG_COUNT_BIT];
    assign clear_discharge_count = clear_reg[cc_regs_pkg::CLR_DSG_COUNT_BIT];

    // ----------------------------------------------------------------
    // Offset register
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!nrst)
            offset_value <= cc_regs_pkg::OFFSET_RESET;
        else if (cal_done && cal_busy_reg)
            offset_value <= cal_offset;
        else if (wr_ofs)
            offset_value <= reg_wdata;
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case (reg_addr)
            cc_regs_pkg::ADDR_MODE_AND_WAKE_THRESHOLD:
                reg_rdata = {override_reg, cal_req_reg, chg_roll_reg, dsg_roll_reg, wake_sel_reg, 1'b0};
            cc_regs_pkg::ADDR_TEMPERATURE_AND_CLEAR:
                reg_rdata = {temp_s2_reg, clear_reg};
            cc_regs_pkg::ADDR_CALIBRATED_OFFSET:
                reg_rdata = offset_value;
            default:
                reg_rdata = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_CAL_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        cal_done && cal_busy_reg |=> !cal_req_reg && offset_value == $past(cal_offset))
        else $error("calibration completion not recorded");
    AST_CAL_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        cal_req_reg && !cal_done && !wr_mode |=> cal_req_reg)
        else $error("calibration request dropped early");
    AST_START_COND: assert property (@(posedge clk) disable iff (!nrst)
        cal_start |-> cal_req_reg && sense_voltage_abs_uv < calibration_threshold_voltage
            && (override_reg || !$past(single_wire_host_line, 2)))
        else $error("calibration started without its conditions");
    AST_OVR_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        cal_done && cal_busy_reg |=> !override_reg)
        else $error("override not cleared after calibration");
    AST_CHG_ROLL: assert property (@(posedge clk) disable iff (!nrst)
        charge_time_wrap |=> chg_roll_reg)
        else $error("charge rollover flag not set");
    AST_DSG_ROLL: assert property (@(posedge clk) disable iff (!nrst)
        discharge_time_wrap |=> dsg_roll_reg)
        else $error("discharge rollover flag not set");
    AST_CLR_PULSE: assert property (@(posedge clk) disable iff (!nrst)
        wr_tc && reg_wdata[4] ##1 !wr_tc |=> !clear_charge_time)
        else $error("clear bit did not self-return");
    AST_CLR_FLAG: assert property (@(posedge clk) disable iff (!nrst)
        clear_charge_time && !charge_time_wrap |=> !chg_roll_reg)
        else $error("charge rollover flag survived clear");
    AST_THRESH: assert property (@(posedge clk) disable iff (!nrst)
        wake_sel_reg == 3'h1 |-> calibration_threshold_voltage == 16'h0F00)
        else $error("threshold wrong");
    COV_CAL: cover property (@(posedge clk) disable iff (!nrst) cal_start ##[1:20] cal_done);
    COV_CLR: cover property (@(posedge clk) disable iff (!nrst) wr_tc && reg_wdata[4:0] == 5'h1F);
    COV_ROLL: cover property (@(posedge clk) disable iff (!nrst) charge_time_wrap && clear_charge_time);
endmodule
